// ==== logic/rbm_pkg.sv ====
// Purpose: shared constants and carriers for the reset and boot-mode block
// Assumes: 32-bit Avalon-MM register window, word aligned
// Notes:   all offsets are byte addresses
package rbm_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] RBM_OFS_PUDR   = 4'h0;
  localparam logic [3:0] RBM_OFS_PEPUR  = 4'h4;
  localparam logic [3:0] RBM_OFS_IRQCFG = 4'h8;
  localparam logic [3:0] RBM_OFS_STAT   = 4'hc;

  // pullup_disable_reg bit positions
  localparam int RBM_PUD_RESET = 0;
  localparam int RBM_PUD_IRQ   = 1;
  localparam int RBM_PUD_BOOT  = 2;
  localparam int RBM_PUD_EMI   = 3;

  // irq config / status / mask layout
  localparam int RBM_IRQ_A     = 0;
  localparam int RBM_IRQ_B     = 1;
  localparam int RBM_CFG_EDGEA = 0;
  localparam int RBM_CFG_EDGEB = 1;
  localparam int RBM_CFG_LOWPW = 2;
  localparam int RBM_CFG_MSKA  = 8;
  localparam int RBM_CFG_MSKB  = 9;

  // boot mode view, status word bits
  localparam int RBM_ST_MODE   = 8;
  localparam int RBM_ST_EMI20  = 9;
  localparam int RBM_ST_SECURE = 10;

  // reset values
  localparam logic [3:0] RBM_PUDR_RST  = 4'h0;
  localparam logic [1:0] RBM_PEPUR_RST = 2'h3;
  localparam logic [2:0] RBM_CFG_RST   = 3'h0;
  localparam logic [1:0] RBM_MASK_RST  = 2'h0;

  // release delay of the internal reset
  localparam int RBM_RST_DLY_NS  = 640;
  localparam int RBM_CLK_MHZ     = 100;
  localparam int RBM_RST_DLY_CYC = (RBM_RST_DLY_NS * RBM_CLK_MHZ + 999) / 1000;

  // boot modes
  typedef enum logic {RBM_MODE_INT, RBM_MODE_EXT} rbm_mode_t;

  typedef struct packed {
    rbm_mode_t mode;
    logic      emi_20bit;
    logic      secured;
  } rbm_boot_t;

  typedef struct packed {
    logic       rst_pin_dis;
    logic       irq_dis;
    logic       boot_dis;
    logic       emi_dis;
    logic [1:0] td_pu_en;
  } rbm_pull_t;

endpackage

// ==== logic/rbm_sync2.sv ====
// Purpose: two-flop synchroniser, one per bit
// Assumes: input is asynchronous to clk_sys
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
module rbm_sync2
  import rbm_pkg::*;
#(
  parameter int W     = 1,
  parameter logic [W-1:0] RST_V = '0
)
(
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      meta_ff <= RST_V;
      dout    <= RST_V;
    end
    else
    begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end

endmodule

// ==== logic/rbm_top.sv ====
// Purpose: reset release, boot-mode latch, strap sampling, ext irq inputs
// Assumes: srst is system power-on reset; pins are asynchronous
// Notes:   registers over Avalon-MM, one wait state on every access
//
// What this block does
// - low reset pin holds chip in reset
// - reset_out mirrors internal reset state
// - power-on reset asserts internal reset
// - pull-up disable bit for reset pin
// - stop/wait: wake_req registered on clk_sys; clockless path is the pad's
// - run modes: irq synchronised before use
// - each irq low-level or falling-edge
// - pull-up disable bit for irq pins
// - boot high means external unless secured; latched only at pin reset release, so srst alone leaves internal
// - timer pins default timer inputs, pull-ups
// - clear enable bit drops timer pull-up
// - secured flash forces internal boot mode
// - external boot follows address strap level
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module rbm_top
  import rbm_pkg::*;
#(
  parameter int RST_DLY_CYC = RBM_RST_DLY_CYC
)
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  // pins
  input  wire logic        reset_pin_n,
  input  wire logic        external_boot_select,
  input  wire logic        ext_mem_addr_mode,
  input  wire logic        flash_secured,
  input  wire logic        ext_irq_a_n,
  input  wire logic        ext_irq_b_n,
  input  wire logic        low_power_mode,
  output logic             reset_out,
  output logic             chip_rst,
  output logic             boot_ext,
  output logic             emi_20bit,
  output logic             reset_pin_pu_en,
  output logic             irq_pu_en,
  output logic             boot_pu_en,
  output logic             emi_pu_en,
  output logic             timer_d_ch0_fn,
  output logic             timer_d_ch1_fn,
  output logic             timer_d_ch0_pu_en,
  output logic             timer_d_ch1_pu_en,
  output logic             irq_req_a,
  output logic             irq_req_b,
  output logic             wake_req
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic       rst_pin_s;
  logic       boot_s;
  logic       emi_s;
  logic       sec_s;
  logic [1:0] irq_s;
  logic       lowpw_s;

  // reset values are the idle pin levels: pin high, irqs high, no low power
  rbm_sync2 #(.W(7), .RST_V(7'h46)) u_sync
  (
    .clk_sys (clk_sys),
    .srst    (srst),
    .din     ({reset_pin_n, external_boot_select, ext_mem_addr_mode,
               flash_secured, ext_irq_b_n, ext_irq_a_n, low_power_mode}),
    .dout    ({rst_pin_s, boot_s, emi_s, sec_s, irq_s, lowpw_s})
  );

  // ****************************************
  // internal reset release
  // ****************************************
  localparam int CW = $clog2(RST_DLY_CYC + 1);
  localparam logic [CW-1:0] DLY_LAST = CW'(RST_DLY_CYC);

  logic [CW-1:0] dly_cnt_ff;
  logic          chip_rst_ff;
  logic          rel_pulse;

  // power-on (srst) and pin reset both restart the count
  always_ff @(posedge clk_sys)
  begin
    if (srst || !rst_pin_s)
    begin
      dly_cnt_ff  <= '0;
      chip_rst_ff <= 1'b1;
    end
    else if (chip_rst_ff)
    begin
      if (dly_cnt_ff == DLY_LAST)
        chip_rst_ff <= 1'b0;
      else
        dly_cnt_ff <= dly_cnt_ff + CW'(1);
    end
  end

  assign rel_pulse = chip_rst_ff && (dly_cnt_ff == DLY_LAST) &&
                     rst_pin_s && !srst;

  // ****************************************
  // boot mode latch
  // ****************************************
  rbm_boot_t boot_ff;
  rbm_boot_t nxt_boot;

  always_comb
  begin
    nxt_boot.secured   = sec_s;
    nxt_boot.mode      = (boot_s && !sec_s) ? RBM_MODE_EXT :
                                              RBM_MODE_INT;
    nxt_boot.emi_20bit = boot_s && !sec_s && emi_s;
  end

  // captured once, at the edge the pin reset is seen released
  logic rst_pin_q_ff;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      // idle level of the pin, so srst alone never looks like a release
      rst_pin_q_ff <= 1'b1;
      boot_ff      <= '0;
    end
    else
    begin
      rst_pin_q_ff <= rst_pin_s;
      if (rst_pin_s && !rst_pin_q_ff)
        boot_ff <= nxt_boot;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [3:0] pudr_ff;
  logic [1:0] pepur_ff;
  logic [2:0] cfg_ff;
  logic [1:0] mask_ff;
  logic [1:0] stat_ff;
  logic       ack_ff;
  logic       acc;
  logic       wr_hit;

  assign acc    = (avs_read || avs_write) && !ack_ff;
  assign wr_hit = avs_write && ack_ff;

  // one wait state: the access completes on the edge after it is seen
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      ack_ff <= 1'b0;
    else
      ack_ff <= acc;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || chip_rst_ff)
    begin
      pudr_ff  <= RBM_PUDR_RST;
      pepur_ff <= RBM_PEPUR_RST;
      cfg_ff   <= RBM_CFG_RST;
      mask_ff  <= RBM_MASK_RST;
    end
    else if (wr_hit && avs_byteenable[0])
    begin
      unique case (avs_address)
        RBM_OFS_PUDR:   pudr_ff  <= avs_writedata[3:0];
        RBM_OFS_PEPUR:  pepur_ff <= avs_writedata[1:0];
        RBM_OFS_IRQCFG: cfg_ff   <= avs_writedata[2:0];
        default:        ;
      endcase
    end
    if (!srst && !chip_rst_ff && wr_hit && avs_byteenable[1] &&
        avs_address == RBM_OFS_IRQCFG)
      mask_ff <= avs_writedata[RBM_CFG_MSKB:RBM_CFG_MSKA];
  end

  function automatic logic [31:0] rd_word(input logic [3:0] a);
    rd_word = 32'h0;
    unique case (a)
      RBM_OFS_PUDR:   rd_word[3:0] = pudr_ff;
      RBM_OFS_PEPUR:  rd_word[1:0] = pepur_ff;
      RBM_OFS_IRQCFG:
      begin
        rd_word[2:0] = cfg_ff;
        rd_word[RBM_CFG_MSKB:RBM_CFG_MSKA] = mask_ff;
      end
      RBM_OFS_STAT:
      begin
        rd_word[1:0]         = stat_ff;
        rd_word[RBM_ST_MODE]   = boot_ff.mode;
        rd_word[RBM_ST_EMI20]  = boot_ff.emi_20bit;
        rd_word[RBM_ST_SECURE] = boot_ff.secured;
      end
      default:        rd_word = 32'h0;
    endcase
  endfunction

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      avs_readdata <= 32'h0;
    else if (acc && avs_read)
      avs_readdata <= rd_word(avs_address);
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !acc;
  end

  // ****************************************
  // external interrupt conditioning
  // ****************************************
  logic [1:0] irq_q_ff;
  logic [1:0] hit;
  logic [1:0] edge_sel;
  logic [1:0] wclr;

  assign edge_sel = cfg_ff[RBM_CFG_EDGEB:RBM_CFG_EDGEA];
  assign wclr     = (wr_hit && avs_byteenable[0] &&
                     avs_address == RBM_OFS_STAT) ? avs_writedata[1:0] : 2'h0;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      irq_q_ff <= 2'h3;
    else
      irq_q_ff <= irq_s;
  end

  // synchronised copy drives service requests in run modes
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      hit[i] = edge_sel[i] ? (irq_q_ff[i] && !irq_s[i]) : !irq_s[i];
  end

  // set wins over a write-one clear
  always_ff @(posedge clk_sys)
  begin
    if (srst || chip_rst_ff)
      stat_ff <= 2'h0;
    else
      stat_ff <= (stat_ff & ~wclr) | hit;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || chip_rst_ff)
    begin
      irq       <= 1'b0;
      irq_req_a <= 1'b0;
      irq_req_b <= 1'b0;
      wake_req  <= 1'b0;
    end
    else
    begin
      irq       <= |(stat_ff & mask_ff);
      irq_req_a <= stat_ff[RBM_IRQ_A];
      irq_req_b <= stat_ff[RBM_IRQ_B];
      // registered summary for wake; the clockless path is the pad's own
      wake_req  <= (lowpw_s || cfg_ff[RBM_CFG_LOWPW]) && !(&irq_s);
    end
  end

  // ****************************************
  // pin outputs
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      reset_out         <= 1'b1;
      chip_rst          <= 1'b1;
      boot_ext          <= 1'b0;
      emi_20bit         <= 1'b0;
      reset_pin_pu_en   <= 1'b1;
      irq_pu_en         <= 1'b1;
      boot_pu_en        <= 1'b1;
      emi_pu_en         <= 1'b1;
      timer_d_ch0_fn    <= 1'b1;
      timer_d_ch1_fn    <= 1'b1;
      timer_d_ch0_pu_en <= 1'b1;
      timer_d_ch1_pu_en <= 1'b1;
    end
    else
    begin
      reset_out         <= chip_rst_ff && !rel_pulse;
      chip_rst          <= chip_rst_ff && !rel_pulse;
      boot_ext          <= boot_ff.mode == RBM_MODE_EXT;
      emi_20bit         <= boot_ff.emi_20bit;
      reset_pin_pu_en   <= !pudr_ff[RBM_PUD_RESET];
      irq_pu_en         <= !pudr_ff[RBM_PUD_IRQ];
      boot_pu_en        <= !pudr_ff[RBM_PUD_BOOT];
      emi_pu_en         <= !pudr_ff[RBM_PUD_EMI];
      timer_d_ch0_fn    <= 1'b1;
      timer_d_ch1_fn    <= 1'b1;
      timer_d_ch0_pu_en <= pepur_ff[0];
      timer_d_ch1_pu_en <= pepur_ff[1];
    end
  end

endmodule

// ==== verification/rbm_top_monitor.sv ====
// Purpose: port-level checks of reset release, boot latch and irq inputs
// Assumes: straps change only while chip_rst is high
// Notes:   rel_cnt_ff counts edges since every reset source let go
`timescale 1ns/100ps
module rbm_top_monitor
  import rbm_pkg::*;
#(
  parameter int RST_DLY_CYC = RBM_RST_DLY_CYC
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reset_pin_n,
  input wire logic external_boot_select,
  input wire logic ext_mem_addr_mode,
  input wire logic flash_secured,
  input wire logic ext_irq_a_n,
  input wire logic ext_irq_b_n,
  input wire logic low_power_mode,
  input wire logic reset_out,
  input wire logic chip_rst,
  input wire logic boot_ext,
  input wire logic emi_20bit,
  input wire logic irq_req_a,
  input wire logic irq_req_b,
  input wire logic timer_d_ch0_fn,
  input wire logic timer_d_ch1_fn,
  input wire logic timer_d_ch0_pu_en,
  input wire logic timer_d_ch1_pu_en
);
  logic [7:0] rel_cnt_ff;

  // saturates so a long run never wraps back into the release window
  always_ff @(posedge clk_sys)
  begin
    if (srst || !reset_pin_n)
      rel_cnt_ff <= 8'h00;
    else if (rel_cnt_ff != 8'hff)
      rel_cnt_ff <= rel_cnt_ff + 8'h01;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  rst_out_a: assert property (reset_out == chip_rst)
    else $error("reset_out differs from chip_rst");
  pin_hold_a: assert property (!reset_pin_n [*5] |-> chip_rst)
    else $error("chip_rst low while reset pin held");
  por_a: assert property ($fell(srst) |-> chip_rst)
    else $error("power-on reset not seen");
  rel_early_a: assert property ($past(chip_rst) &&
    rel_cnt_ff < RST_DLY_CYC |-> chip_rst)
    else $error("internal reset released early");
  rel_late_a: assert property (rel_cnt_ff > RST_DLY_CYC + 4 |-> !chip_rst)
    else $error("internal reset released late");
  boot_hold_a: assert property (!$stable(boot_ext) |-> chip_rst)
    else $error("boot mode moved outside reset");
  boot_sel_a: assert property (!chip_rst |->
    boot_ext == (external_boot_select && !flash_secured))
    else $error("boot mode wrong for straps");
  ext_mem_addr_mode_a: assert property (!chip_rst |->
    emi_20bit == (boot_ext && ext_mem_addr_mode))
    else $error("address mode wrong for straps");
  timer_dflt_a: assert property (chip_rst [*2] |-> timer_d_ch0_fn &&
    timer_d_ch1_fn && timer_d_ch0_pu_en && timer_d_ch1_pu_en)
    else $error("timer pins not at reset default");
  irq_sync_a: assert property ($rose(irq_req_a) && !low_power_mode |->
    !$past(ext_irq_a_n, 4))
    else $error("irq seen without synchroniser delay");
  irq_edge_a: assert property (!chip_rst && $fell(ext_irq_b_n) |->
    ##[1:4] irq_req_b)
    else $error("falling edge on irq b missed");
endmodule

bind rbm_top rbm_top_monitor #(.RST_DLY_CYC(RST_DLY_CYC)) i_rbm_top_monitor (
  .clk_sys, .srst, .reset_pin_n, .external_boot_select, .ext_mem_addr_mode,
  .flash_secured, .ext_irq_a_n, .ext_irq_b_n, .low_power_mode, .reset_out,
  .chip_rst, .boot_ext, .emi_20bit, .irq_req_a, .irq_req_b, .timer_d_ch0_fn,
  .timer_d_ch1_fn, .timer_d_ch0_pu_en, .timer_d_ch1_pu_en);

// ==== verification/rbm_board.sv ====
// Purpose: board side: reset pin, straps, interrupting devices, power mode
// Assumes: driven only through its tasks, one change per edge
// Notes:   straps settle while the pin is still low, before release
`timescale 1ns/100ps
module rbm_board
  import rbm_pkg::*;
(
  input  wire logic clk_sys,
  output logic      reset_pin_n,
  output logic      external_boot_select,
  output logic      ext_mem_addr_mode,
  output logic      flash_secured,
  output logic      ext_irq_a_n,
  output logic      ext_irq_b_n,
  output logic      low_power_mode
);
  initial
  begin
    reset_pin_n = 1'b1;
    {flash_secured, ext_mem_addr_mode, external_boot_select} = 3'h0;
    {ext_irq_a_n, ext_irq_b_n} = 2'h3;
    low_power_mode = 1'b0;
  end

  // trst is not modelled: this is the debug-style reset of the pin alone
  task automatic rst_pin(input logic lvl, input logic [2:0] s);
    @(posedge clk_sys);
    if (lvl)
    begin
      {flash_secured, ext_mem_addr_mode, external_boot_select} <= s;
      repeat (4) @(posedge clk_sys);
    end
    reset_pin_n <= lvl;
  endtask

  task automatic irq_pin(input int c, input logic lvl);
    @(posedge clk_sys);
    if (c == 0)
      ext_irq_a_n <= lvl;
    else
      ext_irq_b_n <= lvl;
  endtask

  task automatic set_lp(input logic v);
    @(posedge clk_sys);
    low_power_mode <= v;
  endtask
endmodule

// ==== verification/testbench.sv ====
// Purpose: register, reset, boot and irq sequences for rbm_top
// Assumes: release delay shortened to 2 cycles
// Notes:   outputs compared on the falling edge, timer pins once on the rising; bus sampled on the rising
`timescale 1ns/100ps
module testbench;
  import rbm_pkg::*;
  localparam int DLY = 2;
  logic        clk_sys, srst, avs_read, avs_write, avs_waitrequest, irq, e;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  logic        reset_pin_n, external_boot_select, ext_mem_addr_mode;
  logic        flash_secured, ext_irq_a_n, ext_irq_b_n, low_power_mode;
  logic        reset_out, chip_rst, boot_ext, emi_20bit, wake_req;
  logic        reset_pin_pu_en, irq_pu_en, boot_pu_en, emi_pu_en;
  logic        timer_d_ch0_fn, timer_d_ch1_fn, irq_req_a, irq_req_b;
  logic        timer_d_ch0_pu_en, timer_d_ch1_pu_en;
  int          error_cnt, tests_run, n;

  rbm_top #(.RST_DLY_CYC(DLY)) i_rbm_top (.clk_sys, .srst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .irq, .reset_pin_n, .external_boot_select,
    .ext_mem_addr_mode, .flash_secured, .ext_irq_a_n, .ext_irq_b_n,
    .low_power_mode, .reset_out, .chip_rst, .boot_ext, .emi_20bit,
    .reset_pin_pu_en, .irq_pu_en, .boot_pu_en, .emi_pu_en, .timer_d_ch0_fn,
    .timer_d_ch1_fn, .timer_d_ch0_pu_en, .timer_d_ch1_pu_en, .irq_req_a,
    .irq_req_b, .wake_req);
  rbm_board i_rbm_board (.clk_sys, .reset_pin_n, .external_boot_select,
    .ext_mem_addr_mode, .flash_secured, .ext_irq_a_n, .ext_irq_b_n,
    .low_power_mode);

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic hang(input string nm);
    error_cnt++;
    $display("mismatch timeout on %s", nm);
    final_report();
  endtask

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    tests_run++;
    if (g !== x)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask

  // request held until waitrequest is seen low, then released
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    avs_address    <= a;
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_writedata  <= d;
    avs_byteenable <= 4'hf;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (k == 20)
      hang("bus");
    rdat = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wait_rst(output int c);
    for (c = 0; c < 200; c++)
    begin
      @(negedge clk_sys);
      if (reset_out === 1'b0)
        break;
    end
    if (c == 200)
      hang("reset");
  endtask

  task automatic settle();
    repeat (6) @(negedge clk_sys);
  endtask

  initial
  begin
    srst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'h0;
    error_cnt = 0;
    tests_run = 0;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    wait_rst(n);
    bus(0, RBM_OFS_PUDR, 0);
    chk("pudr", {28'h0, RBM_PUDR_RST}, rdat);
    bus(0, RBM_OFS_PEPUR, 0);
    chk("pepur", {30'h0, RBM_PEPUR_RST}, rdat);
    bus(0, 4'h2, 0);
    chk("unmapped", 32'h0, rdat);
    chk("timer_pins", 4'hf, {timer_d_ch0_fn, timer_d_ch1_fn,
      timer_d_ch0_pu_en, timer_d_ch1_pu_en});
    for (int i = 0; i < 4; i++)
    begin
      bus(1, RBM_OFS_PUDR, 32'h1 << i);
      settle();
      chk("pull_ups", {28'h0, ~(4'h1 << i)}, {emi_pu_en, boot_pu_en,
        irq_pu_en, reset_pin_pu_en});
    end
    bus(1, RBM_OFS_PEPUR, 32'h1);
    settle();
    chk("timer_pu", 2'h1, {timer_d_ch1_pu_en, timer_d_ch0_pu_en});
    for (int m = 0; m < 8; m++)
    begin
      i_rbm_board.rst_pin(1'b0, 3'h0);
      repeat (10) @(negedge clk_sys);
      chk("held", 1'b1, reset_out);
      i_rbm_board.rst_pin(1'b1, m[2:0]);
      wait_rst(n);
      chk("release_time", 1'b1, n >= DLY && n <= DLY + 6);
      e = m[0] && !m[2];
      chk("boot_ext", e, boot_ext);
      chk("emi_20bit", e && m[1], emi_20bit);
      chk("pu_restored", 1'b1, emi_pu_en);
      bus(0, RBM_OFS_STAT, 0);
      chk("stat_mode", {m[2], e && m[1], e}, rdat[10:8]);
    end
    bus(1, RBM_OFS_IRQCFG, 32'h303);
    for (int c = 0; c < 2; c++)
    begin
      i_rbm_board.irq_pin(c, 1'b0);
      repeat (6) @(posedge clk_sys);
      i_rbm_board.irq_pin(c, 1'b1);
      settle();
      chk("req", 2'h1 << c, {irq_req_b, irq_req_a});
      chk("irq", 1'b1, irq);
      bus(1, RBM_OFS_STAT, 32'h1 << c);
      settle();
      chk("cleared", 3'h0, {irq_req_b, irq_req_a, irq});
    end
    bus(1, RBM_OFS_IRQCFG, 32'h003);
    i_rbm_board.irq_pin(0, 1'b0);
    i_rbm_board.irq_pin(0, 1'b1);
    settle();
    chk("masked", 2'h1, {irq, irq_req_a});
    bus(1, RBM_OFS_IRQCFG, 32'h100);
    bus(1, RBM_OFS_STAT, 32'h3);
    i_rbm_board.irq_pin(0, 1'b0);
    i_rbm_board.set_lp(1'b1);
    settle();
    chk("wake", 1'b1, wake_req);
    bus(1, RBM_OFS_STAT, 32'h1);
    settle();
    chk("level", 2'h3, {irq, irq_req_a});
    i_rbm_board.irq_pin(0, 1'b1);
    i_rbm_board.set_lp(1'b0);
    bus(1, RBM_OFS_STAT, 32'h1);
    settle();
    chk("level_off", 2'h0, {irq, irq_req_a});
    @(posedge clk_sys);
    srst <= 1'b1;
    settle();
    chk("por", 1'b1, reset_out);
    @(posedge clk_sys);
    srst <= 1'b0;
    wait_rst(n);
    chk("por_release", 1'b1, n >= DLY && n <= DLY + 6);
    final_report();
  end
endmodule
